// File: design/sct_pkg.sv
// Package: constants and types of the sampling clock and timestamp block.
package sct_pkg;
   localparam int SMP_W = 8;
   localparam int DLY_STEPS = 256;
   localparam int DLY_W = $clog2(DLY_STEPS);
   localparam int RAMP_CYC = 384;
   localparam logic [8:0] RAMP_TICK_LAST = 9'(RAMP_CYC - 1);
   localparam logic [7:0] RAMP_STEP_SLOW = 8'h01;
   localparam logic [7:0] RAMP_STEP_FAST = 8'h04;
   // Register offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COARSE = 8'h04;
   localparam logic [7:0] OFS_FINE = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_SREF = 8'h10;
   // Control fields and reset values.
   localparam int CTRL_MARK_EN = 0;
   localparam int CTRL_SINGLE = 1;
   localparam int CTRL_INV = 2;
   localparam int CTRL_RAMP_EN = 3;
   localparam int CTRL_RAMP_FAST = 4;
   localparam int CTRL_SREF_EN = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h20;
   localparam logic [7:0] COARSE_RST = 8'h00;
   localparam logic [7:0] FINE_RST = 8'h00;
   // Status fields.
   localparam int STAT_BUSY = 8;
   localparam int STAT_SEEN = 9;
   localparam int SREF_CNT_W = 16;
   typedef enum logic {SCT_RAMP_IDLE, SCT_RAMP_RUN} sct_ramp_st_t;
   typedef struct packed {
      logic invert;
      logic [DLY_W-1:0] coarse;
      logic [DLY_W-1:0] fine;
   } sct_delay_t;
   typedef struct packed {
      logic vld;
      logic [SMP_W-1:0] rise_a;
      logic [SMP_W-1:0] rise_b;
      logic [SMP_W-1:0] fall_a;
   } sct_core_t;
   typedef struct packed {
      logic [1:0] vld;
      logic [1:0][SMP_W-1:0] d;
   } sct_pair_t;
endpackage

// File: design/sct_lsb_mark.sv
// Module: puts the trigger status into the LSB of each sample slot.
`timescale 1ns/1ps
module sct_lsb_mark
   import sct_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Sample pair and trigger.
   input wire sct_pair_t pair_in,
   input wire logic mark_en,
   input wire logic trig,
   // Marked pair.
   output sct_pair_t pair_out
);
   sct_pair_t mark_nxt;
   assign mark_nxt.vld = pair_in.vld;
   genvar g;
   for (g = 0; g < 2; g++) begin : g_slot
      assign mark_nxt.d[g] = mark_en ?
         {pair_in.d[g][SMP_W-1:1], trig} : pair_in.d[g];
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) pair_out <= '0;
      else pair_out <= mark_nxt;
   end
endmodule // sct_lsb_mark

// File: design/sct_delay_ramp.sv
// Module: steps the live coarse delay toward its written target.
`timescale 1ns/1ps
module sct_delay_ramp
   import sct_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control.
   input wire logic ramp_en,
   input wire logic ramp_fast,
   input wire logic load,
   input wire logic [DLY_W-1:0] target,
   // Live setting.
   output logic [DLY_W-1:0] current,
   output logic busy
);
   sct_ramp_st_t st_r, st_nxt;
   logic [8:0] tick_r, tick_nxt;
   logic [DLY_W-1:0] cur_r, cur_nxt;
   wire [7:0] step = ramp_fast ? RAMP_STEP_FAST : RAMP_STEP_SLOW;
   wire up = target > cur_r;
   wire [7:0] gap = up ? target - cur_r : cur_r - target;
   wire tick_done = tick_r == RAMP_TICK_LAST;
   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      tick_nxt = tick_r;
      unique case (st_r)
         SCT_RAMP_IDLE: begin
            if (!ramp_en) cur_nxt = target;
            else if (load) begin
               st_nxt = SCT_RAMP_RUN;
               tick_nxt = 9'h000;
            end
         end
         SCT_RAMP_RUN: begin
            tick_nxt = tick_r + 9'h001;
            if (!ramp_en) begin
               cur_nxt = target;
               st_nxt = SCT_RAMP_IDLE;
            end else if (load) tick_nxt = 9'h000;
            else if (tick_done) begin
               tick_nxt = 9'h000;
               if (gap <= step) begin
                  cur_nxt = target;
                  st_nxt = SCT_RAMP_IDLE;
               end else cur_nxt = up ? cur_r + step : cur_r - step;
            end
         end
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= SCT_RAMP_IDLE;
         tick_r <= 9'h000;
         cur_r <= COARSE_RST;
      end else begin
         st_r <= st_nxt;
         tick_r <= tick_nxt;
         cur_r <= cur_nxt;
      end
   end
   assign current = cur_r;
   assign busy = st_r == SCT_RAMP_RUN;
endmodule // sct_delay_ramp

// File: design/sct_top.sv
// Module: sampling clock control, timing reference capture and marking.
`timescale 1ns/1ps
module sct_top
   import sct_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,

   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,

   // Converter core samples.
   input wire sct_core_t core_smp,

   // Trigger pair.
   input wire logic trigger_mark_input_pos,
   input wire logic trigger_mark_input_neg,

   // Timing reference.
   input wire logic sysref_in,

   // Samples toward the serializer.
   output sct_pair_t out_smp,
   output logic sysref_capture,

   // Clock path controls.
   output sct_delay_t delay_set,
   output logic fall_edge_en
);

   ////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [CTRL_W-1:0] ctrl_r;
   logic [DLY_W-1:0] coarse_tgt_r;
   logic [DLY_W-1:0] fine_r;
   logic seen_r;
   logic seen_nxt;
   logic [SREF_CNT_W-1:0] sref_cnt_r;
   logic [SREF_CNT_W-1:0] sref_per_r;
   logic [SREF_CNT_W-1:0] per_cnt_r;
   logic [31:0] rdata_r;
   sct_pair_t stg_pair_r;
   logic stg_trig_r;
   logic sref_s1_r;
   logic sref_s2_r;
   logic sref_cap_r;
   sct_delay_t delay_r;
   logic [DLY_W-1:0] coarse_cur;
   logic ramp_busy;

   ////////////////////////////////////////////////////////////////////
   // Address decode.

   wire hit_ctrl = reg_addr == OFS_CTRL;
   wire hit_coarse = reg_addr == OFS_COARSE;
   wire hit_fine = reg_addr == OFS_FINE;
   wire hit_stat = reg_addr == OFS_STAT;
   wire hit_sref = reg_addr == OFS_SREF;

   wire wr_ctrl = reg_wr && hit_ctrl;
   wire wr_coarse = reg_wr && hit_coarse;
   wire wr_fine = reg_wr && hit_fine;
   wire wr_stat = reg_wr && hit_stat;
   wire wr_sref = reg_wr && hit_sref;

   ////////////////////////////////////////////////////////////////////
   // Control fields.

   wire mark_en = ctrl_r[CTRL_MARK_EN];
   wire single_mode = ctrl_r[CTRL_SINGLE];
   wire inv_en = ctrl_r[CTRL_INV];
   wire ramp_en = ctrl_r[CTRL_RAMP_EN];
   wire ramp_fast = ctrl_r[CTRL_RAMP_FAST];
   wire sref_en = ctrl_r[CTRL_SREF_EN];

   ////////////////////////////////////////////////////////////////////
   // Software registers.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) ctrl_r <= CTRL_RST;
      else if (wr_ctrl) ctrl_r <= reg_wdata[CTRL_W-1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) coarse_tgt_r <= COARSE_RST;
      else if (wr_coarse) coarse_tgt_r <= reg_wdata[DLY_W-1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) fine_r <= FINE_RST;
      else if (wr_fine) fine_r <= reg_wdata[DLY_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////
   // Coarse delay ramp.

   // The ramp keeps the clock path free of large jumps, which lowers
   // the chance that the serial link drops its alignment.
   // Changes allowed on the fly.
   sct_delay_ramp u_ramp (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .ramp_en (ramp_en),
      .ramp_fast (ramp_fast),
      .load (wr_coarse),
      .target (coarse_tgt_r),
      .current (coarse_cur),
      .busy (ramp_busy)
   );

   ////////////////////////////////////////////////////////////////////
   // Aperture delay output.

   // The three settings are separate fields and any mix is legal.
   // Independent delay fields.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         delay_r <= '0;
      end else begin
         delay_r.invert <= inv_en;
         delay_r.coarse <= coarse_cur;
         delay_r.fine <= fine_r;
      end
   end

   assign delay_set = delay_r;

   ////////////////////////////////////////////////////////////////////
   // Sampling edge selection.

   // Falling edge used in single mode.
   assign fall_edge_en = single_mode;

   // In single mode both slots come from channel A: first the
   // rising-edge sample, then the falling-edge sample of the same
   // clock period. Dual mode carries A and B from the rising edge.
   wire [SMP_W-1:0] slot1_dat = single_mode ?
      core_smp.fall_a : core_smp.rise_b;

   sct_pair_t pair_in;
   assign pair_in.d[0] = core_smp.rise_a;
   assign pair_in.d[1] = slot1_dat;
   assign pair_in.vld = {core_smp.vld, core_smp.vld};

   ////////////////////////////////////////////////////////////////////
   // Capture stage.

   // Differential trigger: high when the true leg is above the other.
   wire trig_level = trigger_mark_input_pos & ~trigger_mark_input_neg;

   // The trigger, the timing reference and the sample are all taken
   // on the same edge, so each mark lands on the sample it belongs to.
   // One clock for capture and output.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stg_pair_r <= '0;
         stg_trig_r <= 1'b0;
         sref_s1_r <= 1'b0;
         sref_s2_r <= 1'b0;
      end else begin
         stg_pair_r <= pair_in;
         stg_trig_r <= mark_en & trig_level;
         sref_s1_r <= sysref_in;
         sref_s2_r <= sref_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sample marking.

   sct_lsb_mark u_mark (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .pair_in (stg_pair_r),
      .mark_en (mark_en),
      .trig (stg_trig_r),
      .pair_out (out_smp)
   );

   ////////////////////////////////////////////////////////////////////
   // Timing reference capture.

   // A rising edge of the reference is taken at a fixed stage, so the
   // latency from the pin to the capture pulse is the same after every
   // start-up. Pulse and periodic forms are handled alike: each rising
   // edge is one event.
   // Fixed capture edge.
   wire sref_edge = sref_en & sref_s1_r & ~sref_s2_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) sref_cap_r <= 1'b0;
      else sref_cap_r <= sref_edge;
   end

   assign sysref_capture = sref_cap_r;

   // Edge count, saturating, so software can tell one pulse from many.
   wire cnt_full = &sref_cnt_r;
   wire per_full = &per_cnt_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) sref_cnt_r <= '0;
      else if (wr_sref) sref_cnt_r <= '0;
      else if (sref_edge && !cnt_full)
         sref_cnt_r <= sref_cnt_r + 16'h0001;
   end

   // Cycles between two edges; the last full period is kept. A single
   // pulse leaves the period at zero, which reads as "not periodic".
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         per_cnt_r <= '0;
         sref_per_r <= '0;
      end else if (wr_sref) begin
         per_cnt_r <= '0;
         sref_per_r <= '0;
      end else if (sref_edge) begin
         per_cnt_r <= 16'h0001;
         sref_per_r <= per_cnt_r;
      end else if (per_cnt_r != 16'h0000 && !per_full) begin
         per_cnt_r <= per_cnt_r + 16'h0001;
      end
   end

   // Sticky flag; a new edge in the clearing cycle keeps it set.
   wire seen_clr = wr_stat && reg_wdata[STAT_SEEN];

   always_comb begin
      seen_nxt = seen_r;
      if (seen_clr) seen_nxt = 1'b0;
      if (sref_edge) seen_nxt = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) seen_r <= 1'b0;
      else seen_r <= seen_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Read path.

   wire [31:0] ctrl_word = {{(32 - CTRL_W){1'b0}}, ctrl_r};
   wire [31:0] coarse_word = {24'h000000, coarse_tgt_r};
   wire [31:0] fine_word = {24'h000000, fine_r};
   wire [31:0] stat_word = {22'h000000 >> 0, seen_r, ramp_busy, coarse_cur};
   wire [31:0] sref_word = {sref_per_r, sref_cnt_r};

   // Unmapped offsets read as zero.
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_word :
      hit_coarse ? coarse_word :
      hit_fine ? fine_word :
      hit_stat ? stat_word :
      hit_sref ? sref_word : 32'h00000000;

   // Data stand only in the cycle after the strobe.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) rdata_r <= 32'h00000000;
      else if (reg_rd) rdata_r <= rd_mux;
      else rdata_r <= 32'h00000000;
   end

   assign reg_rdata = rdata_r;

endmodule // sct_top

// File: verification/sct_props.sv
// Checker: port-level properties of the sampling clock block.
`timescale 1ns/1ps
module sct_props
   import sct_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire sct_core_t core_smp,
   input wire logic trigger_mark_input_pos,
   input wire logic trigger_mark_input_neg,
   input wire logic sysref_in,
   input wire sct_pair_t out_smp,
   input wire logic sysref_capture,
   input wire sct_delay_t delay_set,
   input wire logic fall_edge_en
);
   logic [CTRL_W-1:0] ctrl_r;
   logic [7:0] fine_r;
   logic [7:0] tgt_r;
   logic [2:0] calm_r;
   logic [8:0] gap_r;
   logic step_ok_r;
   wire trig = trigger_mark_input_pos & ~trigger_mark_input_neg;
   wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
   wire wr_crs = reg_wr && reg_addr == OFS_COARSE;
   wire calm = calm_r > 3'h2;
   wire ramp_on = ctrl_r[CTRL_RAMP_EN] && calm;
   wire [7:0] lim = ctrl_r[CTRL_RAMP_FAST] ? RAMP_STEP_FAST : RAMP_STEP_SLOW;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the control registers, so that modes can be judged.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         fine_r <= FINE_RST;
         tgt_r <= COARSE_RST;
         calm_r <= 3'h0;
      end else begin
         if (wr_ctrl) ctrl_r <= reg_wdata[CTRL_W-1:0];
         if (reg_wr && reg_addr == OFS_FINE) fine_r <= reg_wdata[7:0];
         if (wr_crs) tgt_r <= reg_wdata[7:0];
         calm_r <= wr_ctrl ? 3'h0 : calm_r + {2'h0, calm_r != 3'h7};
      end
   end
   // Gap between ramp steps; a target write restarts the interval.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || wr_crs) begin
         gap_r <= 9'h000;
         step_ok_r <= 1'b0;
      end else if ($changed(delay_set.coarse)) begin
         gap_r <= 9'h000;
         step_ok_r <= 1'b1;
      end else begin
         gap_r <= gap_r + {8'h00, gap_r != 9'h1FF};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   mark_lsb_a: assert property (
      calm && ctrl_r[CTRL_MARK_EN] |-> out_smp.d[0][0] == $past(trig, 2)
      && out_smp.d[1][0] == $past(trig, 2)) else $error("lsb lacks trigger");
   mark_off_a: assert property (
      calm && !ctrl_r[CTRL_MARK_EN] |->
      out_smp.d[0] == $past(core_smp.rise_a, 2))
      else $error("first slot is not plain data");
   dual_pair_a: assert property (
      calm && !fall_edge_en |->
      out_smp.d[1][7:1] == $past(core_smp.rise_b[7:1], 2))
      else $error("dual mode second slot wrong");
   single_pair_a: assert property (
      calm && fall_edge_en |->
      out_smp.d[1][7:1] == $past(core_smp.fall_a[7:1], 2))
      else $error("single mode falling slot wrong");
   fall_mode_a: assert property (fall_edge_en == ctrl_r[CTRL_SINGLE])
      else $error("falling edge enable differs from mode");
   sref_cap_a: assert property (
      calm && ctrl_r[CTRL_SREF_EN] && $rose(sysref_in) |-> ##2 sysref_capture)
      else $error("reference edge not captured");
   sref_only_a: assert property (
      sysref_capture |-> $past(sysref_in, 2) && !$past(sysref_in, 3))
      else $error("capture without reference edge");
   inv_fine_a: assert property (
      delay_set.invert == $past(ctrl_r[CTRL_INV]) && delay_set.fine == $past(fine_r))
      else $error("invert or fine delay wrong");
   coarse_jump_a: assert property (
      calm && !ctrl_r[CTRL_RAMP_EN] |-> delay_set.coarse == $past(tgt_r, 2))
      else $error("coarse delay not applied");
   ramp_gap_a: assert property (
      ramp_on && $changed(delay_set.coarse) && step_ok_r |-> gap_r == 9'h17F)
      else $error("ramp step interval wrong");
   ramp_size_a: assert property (
      ramp_on && $changed(delay_set.coarse) |->
      8'(delay_set.coarse - $past(delay_set.coarse)) <= lim
      || 8'($past(delay_set.coarse) - delay_set.coarse) <= lim)
      else $error("ramp step too large");
   cover property (ctrl_r[CTRL_MARK_EN] && calm && trig);
   cover property (sysref_capture);
   cover property (ramp_on && $changed(delay_set.coarse) && step_ok_r);
endmodule // sct_props
bind sct_top sct_props i_sct_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_smp(core_smp),
   .trigger_mark_input_pos(trigger_mark_input_pos),
   .trigger_mark_input_neg(trigger_mark_input_neg), .sysref_in(sysref_in),
   .out_smp(out_smp), .sysref_capture(sysref_capture),
   .delay_set(delay_set), .fall_edge_en(fall_edge_en));

// File: verification/sct_refgen.sv
// Model: external clock generator that supplies the timing reference.
`timescale 1ns/1ps
module sct_refgen #(
   parameter int FRAME_CYC = 10
) (
   input wire logic clk_sys,
   input wire logic periodic,
   input wire logic fire,
   input wire logic [3:0] div,
   output logic sysref
);
   int cnt = 0;
   initial sysref = 1'b0;
   // divided frame rate
   // FRAME_CYC stands for one multiframe; the period spans div of them.
   always @(posedge clk_sys) begin
      if (periodic) begin
         cnt <= (cnt + 1 >= FRAME_CYC * div) ? 0 : cnt + 1;
         sysref <= cnt < FRAME_CYC * div / 2;
      end else begin
         cnt <= 0;
         sysref <= fire;
      end
   end
endmodule // sct_refgen

// File: verification/sampling_clock_and_timestamp_bench.sv
// Testbench: drives the sampling clock block and checks it against a model.
`timescale 1ns/1ps
module sampling_clock_and_timestamp_bench;
   import sct_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   sct_core_t core_smp = '0;
   logic tpos = 1'b0;
   logic tneg = 1'b1;
   logic sysref_in;
   sct_pair_t out_smp;
   logic sysref_capture;
   sct_delay_t delay_set;
   logic fall_edge_en;
   logic periodic = 1'b0;
   logic fire = 1'b0;
   logic [3:0] div = 4'h2;
   logic [15:0] lfsr = 16'h0795;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int nn = 0;
   int m_calm = 0;
   int m_edges = 0;
   int m_per = 0;
   int m_last = -1;
   logic m_seen = 1'b0;
   logic [5:0] m_ctrl = CTRL_RST;
   logic [7:0] m_crs = 8'h00;
   sct_core_t h1, h2;
   logic t1, t2, s1, s2, s3;
   logic [7:0] e0, e1;
   logic [31:0] v;
   logic [7:0] f;
   int t0;
   sct_top i_sct_top (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .core_smp(core_smp),
      .trigger_mark_input_pos(tpos), .trigger_mark_input_neg(tneg),
      .sysref_in(sysref_in), .out_smp(out_smp),
      .sysref_capture(sysref_capture), .delay_set(delay_set),
      .fall_edge_en(fall_edge_en));
   sct_refgen i_sct_refgen (.clk_sys(clk_sys), .periodic(periodic),
      .fire(fire), .div(div), .sysref(sysref_in));
   always #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      if (a == OFS_CTRL) m_ctrl = d[5:0];
      if (a == OFS_CTRL) m_calm = 0;
      if (a == OFS_COARSE) m_crs = d[7:0];
      if (a == OFS_STAT && d[9]) m_seen = 1'b0;
      if (a == OFS_SREF) m_edges = 0;
      if (a == OFS_SREF) m_last = -1;
      if (a == OFS_SREF) m_per = 0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk_sys);
   endtask
   // Polls status until the ramp settles, then checks interval count.
   task automatic ramp(input logic [7:0] tgt, input int steps);
      wr(OFS_COARSE, {24'h0, tgt});
      t0 = nn;
      v = 32'h100;
      for (int k = 0; k < 3000 && v[8] !== 1'b0; k++) rd(OFS_STAT, v);
      chk({24'h0, v[7:0]}, {24'h0, tgt});
      chk((nn - t0) / RAMP_CYC, steps);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      lfsr <= nxt(lfsr);
      core_smp <= {lfsr[2], lfsr[7:0], lfsr[15:8], lfsr[11:4]};
      tpos <= lfsr[3];
      tneg <= lfsr[9];
      if (cyc == 12000) begin
         n_mismatch++;
         conclude();
      end
   end
   // Reference model of the sample path and reference capture.
   always @(negedge clk_sys) begin
      if (!rst_n) m_calm = 0;
      if (rst_n && m_calm > 3) begin
         e0 = h2.rise_a;
         e1 = m_ctrl[CTRL_SINGLE] ? h2.fall_a : h2.rise_b;
         if (m_ctrl[CTRL_MARK_EN]) e0[0] = t2;
         if (m_ctrl[CTRL_MARK_EN]) e1[0] = t2;
         chk({14'h0, out_smp}, {14'h0, {2{h2.vld}}, e1, e0});
         chk(32'(sysref_capture), 32'(m_ctrl[5] & s2 & ~s3));
      end
      if (m_ctrl[CTRL_SREF_EN] && sysref_in && !s1) begin
         m_edges++;
         m_per = (m_last < 0) ? 0 : nn - m_last;
         m_last = nn;
         m_seen = 1'b1;
      end
      h2 = h1;
      h1 = core_smp;
      t2 = t1;
      t1 = tpos & ~tneg;
      s3 = s2;
      s2 = s1;
      s1 = sysref_in;
      m_calm++;
      nn++;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      wr(8'h14, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         rd(8'(i * 4), v);
         chk(v, (i == 0) ? 32'h20 : 32'h0);
      end
      // Every combination of marking and channel mode.
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CTRL, 32'h20 | m);
         rd(OFS_CTRL, v);
         chk(v, 32'h20 | m);
         chk(32'(fall_edge_en), 32'(m[1]));
         repeat (40) @(posedge clk_sys);
      end
      for (int i = 0; i < 4; i++) begin
         f = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h5A : 8'hA5;
         wr(OFS_CTRL, 32'h20 | (i[0] << 2));
         wr(OFS_FINE, {24'h0, f});
         wr(OFS_COARSE, {24'h0, ~f});
         repeat (3) @(posedge clk_sys);
         chk({15'h0, delay_set}, {15'h0, i[0], ~f, f});
      end
      wr(OFS_CTRL, 32'h20);
      wr(OFS_SREF, 32'h0);
      wr(OFS_STAT, 32'h200);
      periodic <= 1'b1;
      repeat (100) @(posedge clk_sys);
      periodic <= 1'b0;
      repeat (30) @(posedge clk_sys);
      rd(OFS_SREF, v);
      chk(v, {m_per[15:0], m_edges[15:0]});
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(OFS_SREF, v);
      chk(v, {m_per[15:0], m_edges[15:0]});
      rd(OFS_STAT, v);
      chk(v, {22'h0, m_seen, 1'b0, m_crs});
      wr(OFS_STAT, 32'h200);
      rd(OFS_STAT, v);
      chk(v, {22'h0, m_seen, 1'b0, m_crs});
      wr(OFS_CTRL, 32'h00);
      repeat (5) @(posedge clk_sys);
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (10) @(posedge clk_sys);
      wr(OFS_COARSE, 32'h0);
      wr(OFS_CTRL, 32'h28);
      ramp(8'h05, 5);
      wr(OFS_CTRL, 32'h38);
      ramp(8'h0E, 3);
      wr(OFS_COARSE, 32'h40);
      repeat (500) @(posedge clk_sys);
      wr(OFS_CTRL, 32'h20);
      repeat (3) @(posedge clk_sys);
      rd(OFS_STAT, v);
      chk(v, {22'h0, m_seen, 1'b0, 8'h40});
      chk({24'h0, delay_set.coarse}, 32'h40);
      conclude();
   end
endmodule // sampling_clock_and_timestamp_bench
